// [core/pmrs_divider.sv]
`timescale 1ns/1ps
module pmrs_divider #(
  parameter int N = 32,
  parameter int D = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [N-1:0] dividend,
  input  wire logic [D-1:0] divisor,
  output logic              busy,
  output logic              done,
  output logic [N-1:0]      quotient
);

  localparam int CNT_W = $clog2(N + 1);

  logic [D:0]       rem;
  logic [D-1:0]     div;
  logic [CNT_W-1:0] count;
  logic [D:0]       trial;

  // Restoring division, one quotient bit per clock
  always_comb begin
    trial = {rem[D-1:0], quotient[N-1]};
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rem      <= '0;
      div      <= '0;
      count    <= '0;
      busy     <= 1'b0;
      done     <= 1'b0;
      quotient <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem      <= '0;
        div      <= divisor;
        quotient <= dividend;
        count    <= CNT_W'(N);
        busy     <= 1'b1;
      end else if (busy) begin
        if (trial >= {1'b0, div}) begin
          rem      <= trial - {1'b0, div};
          quotient <= {quotient[N-2:0], 1'b1};
        end else begin
          rem      <= trial;
          quotient <= {quotient[N-2:0], 1'b0};
        end
        count <= count - CNT_W'(1);
        if (count == CNT_W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule : pmrs_divider

// [core/pmrs_pkg.sv]
package pmrs_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int SAMP_W = 20;
  localparam int TEMP_W = 16;
  localparam int CAL_W  = 16;
  localparam int CUR_W  = 20;
  localparam int PWR_W  = 24;
  localparam int ACC_W  = 40;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 40;
  localparam int DIV_W  = 32;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [5:0] ADDR_CONFIG     = 6'h00;
  localparam logic [5:0] ADDR_CAL        = 6'h02;
  localparam logic [5:0] ADDR_SHUNT      = 6'h04;
  localparam logic [5:0] ADDR_BUS        = 6'h05;
  localparam logic [5:0] ADDR_TEMP       = 6'h06;
  localparam logic [5:0] ADDR_CURRENT    = 6'h07;
  localparam logic [5:0] ADDR_POWER      = 6'h08;
  localparam logic [5:0] ADDR_ENERGY     = 6'h09;
  localparam logic [5:0] ADDR_CHARGE     = 6'h0A;
  localparam logic [5:0] ADDR_STATUS     = 6'h0B;
  localparam logic [5:0] ADDR_TEMP_LIMIT = 6'h10;
  localparam logic [5:0] ADDR_MAKER      = 6'h3E;
  localparam logic [5:0] ADDR_PART       = 6'h3F;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CFG_RANGE_BIT = 0;
  localparam int CFG_CLEAR_BIT = 1;
  localparam int PART_LSB      = 4;
  localparam logic [CAL_W-1:0]  CAL_RST        = 16'h0000;
  localparam logic [TEMP_W-1:0] TEMP_LIMIT_RST = 16'h7FFF;

  // ************************************************************
  // Scaling
  // ************************************************************
  localparam int CUR_SHIFT   = 12;
  localparam int PWR_SHIFT   = 14;
  localparam int ENERGY_FRAC = 4;
  localparam logic [CUR_W-1:0] CUR_MAG_MAX = 20'h7FFFF;
  localparam logic [PWR_W-1:0] PWR_MAX     = 24'hFFFFFF;

endpackage : pmrs_pkg

// [core/pmrs_scaling.sv]
`timescale 1ns/1ps
// Overview of operation
// - Maker identity register reads a fixed 16-bit code over its whole width.
// - Part identity register holds part code in bits 15-4, revision in 3-0.
// - Range select bit clear picks wide shunt range, set picks narrow range.
// - Shunt LSB 312.5 nV wide or 78.125 nV narrow; bus LSB 195.3125 uV.
// - Shunt and bus results are presented as 20-bit values.
// - Shunt result is signed so both current directions are shown.
// - Bus result is a non-negative magnitude only.
// - Die temperature result is signed 16-bit, 7.8125 m degC per LSB.
// - After each shunt sample, current is the shunt result scaled by calibration.
// - A zero calibration value yields a current result of zero.
// - Power is presented as a 24-bit unsigned value.
// - One power LSB equals 3.2 times the current step in watts.
// - Energy is 40-bit unsigned, one LSB equal to 16 power LSBs.
// - Charge is a 40-bit two's complement value that can rise or fall.
// - Energy and charge accumulators wrap around on overflow.
// - Setting the accumulator clear bit zeroes both accumulators.
// - Die temperature compares directly with the signed temperature limit.
module pmrs_scaling #(
  parameter logic [15:0] MAKER_CODE = 16'h4D4B,  // Arbitrary value
  parameter logic [11:0] PART_CODE  = 12'h0A5,   // Arbitrary value
  parameter logic [3:0]  REV_CODE   = 4'h2       // Arbitrary value
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rstn,
  input  wire logic                         sampleValid,
  input  wire logic [pmrs_pkg::SAMP_W-1:0]  shuntSample,
  input  wire logic [pmrs_pkg::SAMP_W-1:0]  busSample,
  input  wire logic [pmrs_pkg::TEMP_W-1:0]  tempSample,
  input  wire logic [pmrs_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic                         regWrEn,
  input  wire logic [15:0]                  regWrData,
  input  wire logic                         regRdEn,
  output logic      [pmrs_pkg::DATA_W-1:0]  regRdData,
  output logic                              regRdValid,
  output logic                              rangeSelect,
  output logic                              overTemp,
  output logic                              convDone
);

  // ************************************************************
  // Declarations
  // ************************************************************
  typedef enum {PM_IDLE, PM_DIVIDE, PM_POWER, PM_ACCUM} pmrs_state_t;

  localparam int SW = pmrs_pkg::SAMP_W;
  localparam int CW = pmrs_pkg::CUR_W;
  localparam int AW = pmrs_pkg::ACC_W;
  localparam int EW = pmrs_pkg::ACC_W + pmrs_pkg::ENERGY_FRAC;

  pmrs_state_t                   state;
  logic [pmrs_pkg::CAL_W-1:0]    shuntCal;
  logic [pmrs_pkg::TEMP_W-1:0]   tempLimit;
  logic                          accClear;
  logic [SW-1:0]                 shuntResult;
  logic [SW-1:0]                 busResult;
  logic [pmrs_pkg::TEMP_W-1:0]   tempResult;
  logic [CW-1:0]                 current;
  logic [pmrs_pkg::PWR_W-1:0]    power;
  logic [EW-1:0]                 energyAcc;
  logic [AW-1:0]                 chargeAcc;
  logic                          shuntNeg;
  logic                          divStart;
  logic                          divDone;
  logic [pmrs_pkg::DIV_W-1:0]    divQuot;
  logic [pmrs_pkg::DIV_W-1:0]    divDividend;
  logic [SW-1:0]                 shuntMag;
  logic [CW-1:0]                 next_current;
  logic [CW-1:0]                 curMag;
  logic [2*SW-1:0]               powerProd;
  logic [pmrs_pkg::PWR_W-1:0]    next_power;
  logic [pmrs_pkg::DATA_W-1:0]   next_rdData;
  logic                          sampleTaken;

  function automatic logic [SW-1:0] absVal(input logic [SW-1:0] v);
    absVal = v[SW-1] ? SW'(-v) : v;
  endfunction : absVal

  function automatic logic regHit(input logic [pmrs_pkg::ADDR_W-1:0] a, input logic [5:0] target);
    regHit = (a == target);
  endfunction : regHit

  assign sampleTaken = (state == PM_IDLE) && sampleValid;

  // ************************************************************
  // Host-written registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rangeSelect <= 1'b0;
      shuntCal    <= pmrs_pkg::CAL_RST;
      tempLimit   <= pmrs_pkg::TEMP_LIMIT_RST;
    end else if (regWrEn) begin
      if (regHit(regAddr, pmrs_pkg::ADDR_CONFIG)) begin
        rangeSelect <= regWrData[pmrs_pkg::CFG_RANGE_BIT];
      end else if (regHit(regAddr, pmrs_pkg::ADDR_CAL)) begin
        shuntCal <= regWrData;
      end else if (regHit(regAddr, pmrs_pkg::ADDR_TEMP_LIMIT)) begin
        tempLimit <= regWrData;
      end
    end
  end

  // Clear bit is a one-shot; it never reads back as set
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      accClear <= 1'b0;
    end else begin
      accClear <= regWrEn && regHit(regAddr, pmrs_pkg::ADDR_CONFIG)
                  && regWrData[pmrs_pkg::CFG_CLEAR_BIT];
    end
  end

  // ************************************************************
  // Sample capture
  // ************************************************************
  // Samples arriving while a calculation runs are dropped, keeping results coherent
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shuntResult <= '0;
      busResult   <= '0;
      tempResult  <= '0;
    end else if (sampleTaken) begin
      shuntResult <= shuntSample;
      busResult   <= busSample[SW-1] ? '0 : busSample;
      tempResult  <= tempSample;
    end
  end

  // ************************************************************
  // Calculation sequence
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= PM_IDLE;
    end else begin
      case (state)
        PM_IDLE: begin
          if (sampleValid) begin
            state <= (shuntCal == '0) ? PM_POWER : PM_DIVIDE;
          end
        end
        PM_DIVIDE: begin
          if (divDone) begin
            state <= PM_POWER;
          end
        end
        PM_POWER: begin
          state <= PM_ACCUM;
        end
        default: begin
          state <= PM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      divStart <= 1'b0;
      shuntNeg <= 1'b0;
    end else begin
      divStart <= sampleTaken && (shuntCal != '0);
      if (sampleTaken) begin
        shuntNeg <= shuntSample[SW-1];
      end
    end
  end

  // Both ranges reduce to |shunt| * 4096 / cal, since the narrow-range cal is 4x
  assign shuntMag    = absVal(shuntResult);
  assign divDividend = pmrs_pkg::DIV_W'({shuntMag, {pmrs_pkg::CUR_SHIFT{1'b0}}});

  pmrs_divider #(
    .N (pmrs_pkg::DIV_W),
    .D (pmrs_pkg::CAL_W)
  ) u_divider (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .start    (divStart),
    .dividend (divDividend),
    .divisor  (shuntCal),
    .busy     (),
    .done     (divDone),
    .quotient (divQuot)
  );

  // Saturate magnitude, then restore sign
  always_comb begin
    if (divQuot > pmrs_pkg::DIV_W'(pmrs_pkg::CUR_MAG_MAX)) begin
      curMag = pmrs_pkg::CUR_MAG_MAX;
    end else begin
      curMag = divQuot[CW-1:0];
    end
    next_current = shuntNeg ? CW'(-curMag) : curMag;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      current <= '0;
    end else if (sampleTaken && shuntCal == '0) begin
      current <= '0;
    end else if (state == PM_DIVIDE && divDone) begin
      current <= next_current;
    end
  end

  // Power LSB of 3.2 current steps makes power = |I| * V / 16384
  always_comb begin
    powerProd = absVal(current) * busResult;
    if (|powerProd[2*SW-1:pmrs_pkg::PWR_SHIFT+pmrs_pkg::PWR_W]) begin
      next_power = pmrs_pkg::PWR_MAX;
    end else begin
      next_power = powerProd[pmrs_pkg::PWR_SHIFT +: pmrs_pkg::PWR_W];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      power <= '0;
    end else if (state == PM_POWER) begin
      power <= next_power;
    end
  end

  // ************************************************************
  // Accumulators
  // ************************************************************
  // Four hidden fraction bits give the 16:1 energy scale; wrap is natural
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      energyAcc <= '0;
      chargeAcc <= '0;
    end else if (accClear) begin
      energyAcc <= '0;
      chargeAcc <= '0;
    end else if (state == PM_ACCUM) begin
      energyAcc <= energyAcc + EW'(power);
      chargeAcc <= chargeAcc + {{(AW - CW){current[CW-1]}}, current};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      convDone <= 1'b0;
      overTemp <= 1'b0;
    end else begin
      convDone <= (state == PM_ACCUM);
      overTemp <= $signed(tempResult) > $signed(tempLimit);
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  always_comb begin
    next_rdData = '0;
    if (regHit(regAddr, pmrs_pkg::ADDR_CONFIG)) begin
      next_rdData[pmrs_pkg::CFG_RANGE_BIT] = rangeSelect;
    end else if (regHit(regAddr, pmrs_pkg::ADDR_CAL)) begin
      next_rdData = pmrs_pkg::DATA_W'(shuntCal);
    end else if (regHit(regAddr, pmrs_pkg::ADDR_SHUNT)) begin
      next_rdData = pmrs_pkg::DATA_W'(shuntResult);
    end else if (regHit(regAddr, pmrs_pkg::ADDR_BUS)) begin
      next_rdData = pmrs_pkg::DATA_W'(busResult);
    end else if (regHit(regAddr, pmrs_pkg::ADDR_TEMP)) begin
      next_rdData = pmrs_pkg::DATA_W'(tempResult);
    end else if (regHit(regAddr, pmrs_pkg::ADDR_CURRENT)) begin
      next_rdData = pmrs_pkg::DATA_W'(current);
    end else if (regHit(regAddr, pmrs_pkg::ADDR_POWER)) begin
      next_rdData = pmrs_pkg::DATA_W'(power);
    end else if (regHit(regAddr, pmrs_pkg::ADDR_ENERGY)) begin
      next_rdData = energyAcc[EW-1:pmrs_pkg::ENERGY_FRAC];
    end else if (regHit(regAddr, pmrs_pkg::ADDR_CHARGE)) begin
      next_rdData = chargeAcc;
    end else if (regHit(regAddr, pmrs_pkg::ADDR_STATUS)) begin
      next_rdData[0] = overTemp;
      next_rdData[1] = (state != PM_IDLE);
    end else if (regHit(regAddr, pmrs_pkg::ADDR_TEMP_LIMIT)) begin
      next_rdData = pmrs_pkg::DATA_W'(tempLimit);
    end else if (regHit(regAddr, pmrs_pkg::ADDR_MAKER)) begin
      next_rdData = pmrs_pkg::DATA_W'(MAKER_CODE);
    end else if (regHit(regAddr, pmrs_pkg::ADDR_PART)) begin
      next_rdData = pmrs_pkg::DATA_W'({PART_CODE, REV_CODE});
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regRdData  <= '0;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= next_rdData;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  chk_maker_code: assert property (@(posedge clk_sys) disable iff (!rstn)
    regRdEn && regAddr == pmrs_pkg::ADDR_MAKER |=> regRdValid && regRdData == pmrs_pkg::DATA_W'(MAKER_CODE))
    else $error("maker code read wrong");

  chk_part_fields: assert property (@(posedge clk_sys) disable iff (!rstn)
    regRdEn && regAddr == pmrs_pkg::ADDR_PART
    |=> regRdData[15:pmrs_pkg::PART_LSB] == PART_CODE && regRdData[3:0] == REV_CODE)
    else $error("part or revision field wrong");

  chk_range_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    regWrEn && regAddr == pmrs_pkg::ADDR_CONFIG |=> rangeSelect == $past(regWrData[pmrs_pkg::CFG_RANGE_BIT]))
    else $error("range select not stored");

  chk_bus_clamp: assert property (@(posedge clk_sys) disable iff (!rstn)
    sampleTaken && busSample[SW-1] |=> busResult == '0)
    else $error("negative bus sample not clamped");

  chk_cal_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    sampleTaken && shuntCal == '0 |=> state == PM_POWER && current == '0)
    else $error("zero calibration gave nonzero current");

  chk_div_bound: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(state == PM_DIVIDE) |-> ##[1:40] state == PM_POWER)
    else $error("current not computed in time");

  chk_energy_add: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == PM_ACCUM && !accClear |=> energyAcc == $past(energyAcc) + EW'($past(power)) && convDone)
    else $error("energy not accumulated");

  chk_charge_add: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == PM_ACCUM && !accClear |=> $signed(chargeAcc) == $signed($past(chargeAcc)) + $signed($past(current)))
    else $error("charge not accumulated");

  chk_acc_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    regWrEn && regAddr == pmrs_pkg::ADDR_CONFIG && regWrData[pmrs_pkg::CFG_CLEAR_BIT]
    |=> ##1 energyAcc == '0 && chargeAcc == '0)
    else $error("accumulators not cleared");

  chk_over_temp: assert property (@(posedge clk_sys) disable iff (!rstn)
    ##1 overTemp == ($signed($past(tempResult)) > $signed($past(tempLimit))))
    else $error("over-temperature compare wrong");

endmodule : pmrs_scaling

// [tb/pmrs_host_model.sv]
`timescale 1ns/1ps
// ******************************************
// Host side of the register port
// ******************************************
module pmrs_host_model (
  input  wire logic                        clk_sys,
  output logic [pmrs_pkg::ADDR_W-1:0]      regAddr,
  output logic                             regWrEn,
  output logic [15:0]                      regWrData,
  output logic                             regRdEn,
  input  wire logic [pmrs_pkg::DATA_W-1:0] regRdData,
  input  wire logic                        regRdValid
);
  initial begin
    regAddr   = 6'h15;
    regWrEn   = 1'b0;
    regWrData = 16'h5A5A;
    regRdEn   = 1'b0;
  end

  // Idle lines flip so a stale address or data is never trusted
  // Also carries calibration loads and accumulator clears
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge clk_sys);
    regWrEn   = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [39:0] d, output bit ok);
    int i;
    @(negedge clk_sys);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk_sys);
    regRdEn = 1'b0;
    regAddr = ~a;
    ok      = 1'b0;
    d       = 40'h0000000000;
    for (i = 0; i < 4 && !ok; i++) begin
      if (regRdValid === 1'b1) begin
        ok = 1'b1;
        d  = regRdData;
      end else begin
        @(negedge clk_sys);
      end
    end
  endtask : rd
endmodule : pmrs_host_model

// [tb/testbench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nFail++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  localparam logic [15:0] MAKER_VAL = 16'h4A52; // Arbitrary value
  localparam logic [11:0] PART_VAL  = 12'h2A6;  // Arbitrary value
  localparam logic [3:0]  REV_VAL   = 4'h5;     // Arbitrary value

  logic        clk_sys;
  logic        rstn;
  logic        sampleValid;
  logic [19:0] shuntSample;
  logic [19:0] busSample;
  logic [15:0] tempSample;
  logic [5:0]  regAddr;
  logic        regWrEn;
  logic [15:0] regWrData;
  logic        regRdEn;
  logic [39:0] regRdData;
  logic        regRdValid;
  logic        rangeSelect;
  logic        overTemp;
  logic        convDone;
  int          nFail;
  int          nTests;

  pmrs_scaling #(.MAKER_CODE(MAKER_VAL), .PART_CODE(PART_VAL), .REV_CODE(REV_VAL)) uut (
    .clk_sys(clk_sys), .rstn(rstn), .sampleValid(sampleValid), .shuntSample(shuntSample),
    .busSample(busSample), .tempSample(tempSample), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .rangeSelect(rangeSelect), .overTemp(overTemp), .convDone(convDone)
  );

  pmrs_host_model host (
    .clk_sys(clk_sys), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic endOfTest();
    if (nFail == 0 && nTests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : endOfTest

  task automatic readChk(input logic [5:0] a, input logic [39:0] e);
    logic [39:0] d;
    bit          ok;
    host.rd(a, d, ok);
    if (!ok) begin
      nFail++;
      endOfTest();
    end else begin
      `CHK(d, e)
    end
  endtask : readChk

  // ******************************************
  // Converter sample with latency check
  // ******************************************
  task automatic conv(input logic [19:0] sh, input logic [19:0] bu, input logic [15:0] te, input int lat);
    int k;
    @(negedge clk_sys);
    shuntSample = sh;
    busSample   = bu;
    tempSample  = te;
    sampleValid = 1'b1;
    @(negedge clk_sys);
    sampleValid = 1'b0;
    k = 1;
    while (convDone !== 1'b1 && k < 60) begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 60) begin
      nFail++;
      endOfTest();
    end else begin
      `CHK(k, lat)
    end
  endtask : conv

  // ******************************************
  // Main sequence
  // ******************************************
  initial begin
    nFail       = 0;
    nTests      = 0;
    rstn        = 1'b0;
    sampleValid = 1'b0;
    shuntSample = 20'h00000;
    busSample   = 20'h00000;
    tempSample  = 16'h0000;
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    readChk(pmrs_pkg::ADDR_CONFIG, 40'h0000000000);
    readChk(pmrs_pkg::ADDR_TEMP_LIMIT, 40'h0000007FFF);
    readChk(pmrs_pkg::ADDR_MAKER, {24'h000000, MAKER_VAL});
    readChk(pmrs_pkg::ADDR_PART, {24'h000000, PART_VAL, REV_VAL});
    host.wr(pmrs_pkg::ADDR_MAKER, 16'h0000);
    host.wr(pmrs_pkg::ADDR_PART, 16'h0000);
    readChk(pmrs_pkg::ADDR_MAKER, {24'h000000, MAKER_VAL});
    readChk(pmrs_pkg::ADDR_PART, {24'h000000, PART_VAL, REV_VAL});
    readChk(6'h20, 40'h0000000000);
    host.wr(pmrs_pkg::ADDR_CONFIG, 16'h0001);
    `CHK(rangeSelect, 1'b1)
    readChk(pmrs_pkg::ADDR_CONFIG, 40'h0000000001);
    host.wr(pmrs_pkg::ADDR_CONFIG, 16'h0000);
    `CHK(rangeSelect, 1'b0)
    // Zero calibration: short path, no current
    conv(20'h00100, 20'h04000, 16'h0100, 3);
    readChk(pmrs_pkg::ADDR_CURRENT, 40'h0000000000);
    readChk(pmrs_pkg::ADDR_POWER, 40'h0000000000);
    readChk(pmrs_pkg::ADDR_SHUNT, 40'h0000000100);
    readChk(pmrs_pkg::ADDR_BUS, 40'h0000004000);
    readChk(pmrs_pkg::ADDR_TEMP, 40'h0000000100);
    // Calibration 4096 makes current equal the shunt code
    host.wr(pmrs_pkg::ADDR_CAL, 16'h1000);
    readChk(pmrs_pkg::ADDR_CAL, 40'h0000001000);
    // Status shows busy while the divide runs
    fork
      conv(20'h00100, 20'h04000, 16'h0080, 37);
      begin
        repeat (4) @(negedge clk_sys);
        readChk(pmrs_pkg::ADDR_STATUS, 40'h0000000002);
      end
    join
    readChk(pmrs_pkg::ADDR_CURRENT, 40'h0000000100);
    readChk(pmrs_pkg::ADDR_POWER, 40'h0000000100);
    readChk(pmrs_pkg::ADDR_ENERGY, 40'h0000000010);
    readChk(pmrs_pkg::ADDR_CHARGE, 40'h0000000100);
    conv(20'hFFE00, 20'h04000, 16'hFF00, 37);
    readChk(pmrs_pkg::ADDR_CURRENT, 40'h00000FFE00);
    readChk(pmrs_pkg::ADDR_SHUNT, 40'h00000FFE00);
    readChk(pmrs_pkg::ADDR_TEMP, 40'h000000FF00);
    readChk(pmrs_pkg::ADDR_POWER, 40'h0000000200);
    readChk(pmrs_pkg::ADDR_ENERGY, 40'h0000000030);
    readChk(pmrs_pkg::ADDR_CHARGE, 40'hFFFFFFFF00);
    // Negative bus code reads as zero and yields no power
    conv(20'h00100, 20'h80000, 16'h0000, 37);
    readChk(pmrs_pkg::ADDR_BUS, 40'h0000000000);
    readChk(pmrs_pkg::ADDR_POWER, 40'h0000000000);
    readChk(pmrs_pkg::ADDR_ENERGY, 40'h0000000030);
    // Signed compare: an unsigned one would flag 0xFF00
    host.wr(pmrs_pkg::ADDR_TEMP_LIMIT, 16'h0080);
    conv(20'h00000, 20'h00000, 16'h0100, 37);
    `CHK(overTemp, 1'b1)
    readChk(pmrs_pkg::ADDR_STATUS, 40'h0000000001);
    conv(20'h00000, 20'h00000, 16'hFF00, 37);
    `CHK(overTemp, 1'b0)
    // Calibration 1 drives the quotient past the clamp
    host.wr(pmrs_pkg::ADDR_CAL, 16'h0001);
    conv(20'h40000, 20'h00000, 16'h0000, 37);
    readChk(pmrs_pkg::ADDR_CURRENT, 40'h000007FFFF);
    host.wr(pmrs_pkg::ADDR_CONFIG, 16'h0002);
    repeat (3) @(negedge clk_sys);
    readChk(pmrs_pkg::ADDR_ENERGY, 40'h0000000000);
    readChk(pmrs_pkg::ADDR_CHARGE, 40'h0000000000);
    readChk(pmrs_pkg::ADDR_CONFIG, 40'h0000000000);
    endOfTest();
  end
endmodule : testbench
